// File: rtl/usb_irq_pkg.sv
package usb_irq_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses are four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] in_flags_index = 8'h02;
   localparam logic [7:0] frame_high_index = 8'h0d;
   localparam logic [7:0] irq_mask_index = 8'h20;
   localparam logic [7:0] cpu_enable_index = 8'h21;
   localparam logic [7:0] status_index = 8'h22;
   localparam logic [7:0] events_mask_index = 8'h23;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int frame_high_width = 3;
   localparam int in_flags_width = 4;
   localparam int control_ep_bit = 0;
   localparam logic [7:0] flags_reset = 8'h00;
   localparam logic [7:0] frame_high_reset = 8'h00;
   localparam logic [31:0] unmapped_read = 32'h00000000;

   // Sticky event bits in the status register
   localparam int ev_in_flag_bit = 0;
   localparam int ev_frame_bit = 1;
   localparam int ev_width = 2;

   // Wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] index;
      logic [31:0] data;
   } wb_req_t;

   typedef enum logic {
      bus_idle,
      bus_acked
   } bus_state_t;

endpackage

// File: rtl/usb_function_irq_flags_frame_high.sv
`timescale 1ns/1ns

module usb_function_irq_flags_frame_high (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [9:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [3:0] in_event_in,
   input wire logic frame_valid_in,
   input wire logic [10:0] frame_number_in,
   output logic usb_irq_request_out,
   output logic cpu_irq_out,
   output logic irq_out
);

   // ------------------------------------------------------------
   // Bus request decode
   // ------------------------------------------------------------
   usb_irq_pkg::wb_req_t req;
   logic access;
   logic wr;
   logic rd;

   // Word aligned decode; low two address bits ignored
   always_comb begin
      req.cyc = wb_cyc_in;
      req.stb = wb_stb_in;
      req.we = wb_we_in;
      req.sel = wb_sel_in;
      req.index = wb_adr_in[9:2];
      req.data = wb_dat_in;
   end

   // Ack is given one cycle after the request, for exactly one cycle
   // Side effects land on the request edge; the master holds its request until ack anyway
   usb_irq_pkg::bus_state_t bus_state;
   usb_irq_pkg::bus_state_t next_bus_state;
   assign access = req.cyc && req.stb && (bus_state == usb_irq_pkg::bus_idle);
   assign wr = access && req.we;
   assign rd = access && !req.we;

   function automatic logic hit(input logic [7:0] index, input logic [7:0] want);
      hit = (index == want);
   endfunction

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   logic [3:0] in_flags;
   logic [3:0] next_in_flags;
   logic [2:0] frame_high;
   logic [2:0] next_frame_high;
   logic [3:0] irq_mask;
   logic [3:0] next_irq_mask;
   logic cpu_enable;
   logic next_cpu_enable;
   logic [1:0] status;
   logic [1:0] next_status;
   logic [1:0] ev_mask;
   logic [1:0] next_ev_mask;
   logic [31:0] next_rdata;
   logic next_ack;

   // Flag set beats the read clear so a same-cycle event is never lost
   always_comb begin
      next_in_flags = in_flags;
      if (rd && hit(req.index, usb_irq_pkg::in_flags_index)) begin
         next_in_flags = '0;
      end
      next_in_flags = next_in_flags | in_event_in;
   end

   // Upper frame bits follow each received frame
   always_comb begin
      next_frame_high = frame_high;
      if (frame_valid_in) begin
         next_frame_high = frame_number_in[10:8];
      end
   end

   // Software owned enables; flags themselves accept no writes
   always_comb begin
      next_irq_mask = irq_mask;
      next_cpu_enable = cpu_enable;
      next_ev_mask = ev_mask;
      if (wr && req.sel[0]) begin
         if (hit(req.index, usb_irq_pkg::irq_mask_index)) begin
            next_irq_mask = req.data[3:0];
         end
         if (hit(req.index, usb_irq_pkg::cpu_enable_index)) begin
            next_cpu_enable = req.data[0];
         end
         if (hit(req.index, usb_irq_pkg::events_mask_index)) begin
            next_ev_mask = req.data[1:0];
         end
      end
   end

   // Sticky events: new flag and new frame; write one clears, set wins
   always_comb begin
      next_status = status;
      if (wr && req.sel[0] && hit(req.index, usb_irq_pkg::status_index)) begin
         next_status = status & ~req.data[1:0];
      end
      if (|in_event_in) begin
         next_status[usb_irq_pkg::ev_in_flag_bit] = 1'b1;
      end
      if (frame_valid_in) begin
         next_status[usb_irq_pkg::ev_frame_bit] = 1'b1;
      end
   end

   // Read mux; unused bits and unmapped indexes read zero
   always_comb begin
      next_rdata = usb_irq_pkg::unmapped_read;
      next_ack = 1'b0;
      next_bus_state = usb_irq_pkg::bus_idle;
      case (bus_state)
         usb_irq_pkg::bus_idle: begin
            if (access) begin
               next_ack = 1'b1;
               next_bus_state = usb_irq_pkg::bus_acked;
               if (rd) begin
                  case (req.index)
                     usb_irq_pkg::in_flags_index: next_rdata = {28'h0000000, in_flags};
                     usb_irq_pkg::frame_high_index: next_rdata = {29'h00000000, frame_high};
                     usb_irq_pkg::irq_mask_index: next_rdata = {28'h0000000, irq_mask};
                     usb_irq_pkg::cpu_enable_index: next_rdata = {31'h00000000, cpu_enable};
                     usb_irq_pkg::status_index: next_rdata = {30'h00000000, status};
                     usb_irq_pkg::events_mask_index: next_rdata = {30'h00000000, ev_mask};
                     default: next_rdata = usb_irq_pkg::unmapped_read;
                  endcase
               end
            end
         end
         usb_irq_pkg::bus_acked: begin
            next_bus_state = usb_irq_pkg::bus_idle;
         end
         default: begin
            next_bus_state = usb_irq_pkg::bus_idle;
         end
      endcase
   end

   // Register everything on the single clock
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         in_flags <= usb_irq_pkg::flags_reset[3:0];
         frame_high <= usb_irq_pkg::frame_high_reset[2:0];
         irq_mask <= 4'h0;
         cpu_enable <= 1'b0;
         status <= 2'h0;
         ev_mask <= 2'h0;
         wb_dat_out <= 32'h00000000;
         wb_ack_out <= 1'b0;
         bus_state <= usb_irq_pkg::bus_idle;
      end else begin
         in_flags <= next_in_flags;
         frame_high <= next_frame_high;
         irq_mask <= next_irq_mask;
         cpu_enable <= next_cpu_enable;
         status <= next_status;
         ev_mask <= next_ev_mask;
         wb_dat_out <= next_rdata;
         wb_ack_out <= next_ack;
         bus_state <= next_bus_state;
      end
   end

   // ------------------------------------------------------------
   // Interrupt outputs
   // ------------------------------------------------------------
   // Masks reset to zero, so software must enable a source before it can interrupt
   // Request follows enabled flags; the processor gate is the cpu_enable register in the map
   assign usb_irq_request_out = |(in_flags & irq_mask);
   assign cpu_irq_out = usb_irq_request_out && cpu_enable;
   assign irq_out = |(status & ev_mask);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   read_clears_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (rd && req.index == usb_irq_pkg::in_flags_index && in_event_in == 4'h0) |=> in_flags == 4'h0)
      else $error("flag read did not clear flags");
   read_returns_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rd && req.index == usb_irq_pkg::in_flags_index |=> wb_dat_out[3:0] == $past(in_flags) && wb_ack_out)
      else $error("flag read returned wrong value");
   flag_sets_a: assert property (@(posedge clock_in) disable iff (rst_in)
      in_event_in[3] |=> in_flags[3])
      else $error("endpoint flag not set");
   request_level_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (in_flags & irq_mask) != 4'h0 |-> usb_irq_request_out)
      else $error("interrupt request missing");
   cpu_gate_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !cpu_enable |-> !cpu_irq_out)
      else $error("cpu interrupt without enable");
   frame_capture_a: assert property (@(posedge clock_in) disable iff (rst_in)
      frame_valid_in |=> frame_high == $past(frame_number_in[10:8]))
      else $error("frame high not captured");
   upper_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wb_ack_out |-> wb_dat_out[31:4] == 28'h0000000)
      else $error("unused bits not zero");
   no_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (wr && in_event_in == 4'h0 && !rd) |=> in_flags == $past(in_flags))
      else $error("write changed flags");
   ack_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held too long");
   // Every request gets its ack on the next edge, and nothing else raises it
   ack_follows_a: assert property (@(posedge clock_in) disable iff (rst_in)
      access |=> wb_ack_out)
      else $error("request not acknowledged");
   ack_only_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !access |=> !wb_ack_out)
      else $error("ack without a request");
   // The ack cycle itself must never start a second transfer
   idle_after_ack_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wb_ack_out |-> !access)
      else $error("request taken during ack");
   // Writes answer with zero data so a stale read value never rides along
   write_data_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wr |=> wb_dat_out == 32'h00000000)
      else $error("write ack carried data");
   // Anything beyond the map reads as zero
   unmapped_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rd && req.index > usb_irq_pkg::events_mask_index |=> wb_dat_out == usb_irq_pkg::unmapped_read)
      else $error("unmapped read not zero");

   // ------------------------------------------------------------
   // Reset and frame number checks
   // ------------------------------------------------------------
   // The flag and frame high registers leave reset cleared, not only the bus logic
   reset_values_a: assert property (@(posedge clock_in) disable iff (rst_in)
      $past(rst_in) |-> in_flags == 4'h0 && frame_high == 3'h0)
      else $error("register not cleared by reset");
   // Between frames the upper bits must not drift
   frame_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !frame_valid_in |=> frame_high == $past(frame_high))
      else $error("frame high changed without a frame");
   frame_read_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rd && req.index == usb_irq_pkg::frame_high_index |=> wb_dat_out == {29'h00000000, $past(frame_high)})
      else $error("frame high read returned wrong value");
   // A write to the read-only frame register must leave it alone
   frame_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wr && req.index == usb_irq_pkg::frame_high_index && !frame_valid_in |=> frame_high == $past(frame_high))
      else $error("write reached frame high");

   // ------------------------------------------------------------
   // Flag register checks
   // ------------------------------------------------------------
   // Per source: an event always lands, and nothing but a flag read removes it
   for (genvar i = 0; i < usb_irq_pkg::in_flags_width; i++) begin : g_flag_bits
      flag_bit_sets_a: assert property (@(posedge clock_in) disable iff (rst_in)
         in_event_in[i] |=> in_flags[i])
         else $error("source flag not set");
      flag_bit_holds_a: assert property (@(posedge clock_in) disable iff (rst_in)
         !in_event_in[i] && !(rd && req.index == usb_irq_pkg::in_flags_index)
         |=> in_flags[i] == $past(in_flags[i]))
         else $error("source flag changed on its own");
   end
   // Reading some other register must not disturb the flags
   other_read_keeps_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rd && req.index != usb_irq_pkg::in_flags_index && in_event_in == 4'h0 |=> in_flags == $past(in_flags))
      else $error("foreign read cleared flags");

   // ------------------------------------------------------------
   // Interrupt output checks
   // ------------------------------------------------------------
   // With no enabled flag the request must fall again
   request_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (in_flags & irq_mask) == 4'h0 |-> !usb_irq_request_out)
      else $error("interrupt request without a flag");
   // The processor line needs both the request and its own enable
   cpu_pass_a: assert property (@(posedge clock_in) disable iff (rst_in)
      usb_irq_request_out && cpu_enable |-> cpu_irq_out)
      else $error("enabled request not delivered");
   cpu_needs_request_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !usb_irq_request_out |-> !cpu_irq_out)
      else $error("cpu interrupt without request");
   // Enable registers take their value from the low byte lane only
   mask_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wr && req.sel[0] && req.index == usb_irq_pkg::irq_mask_index |=> irq_mask == $past(req.data[3:0]))
      else $error("mask write lost");
   cpu_enable_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wr && req.sel[0] && req.index == usb_irq_pkg::cpu_enable_index |=> cpu_enable == $past(req.data[0]))
      else $error("processor enable write lost");
   ev_mask_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wr && req.sel[0] && req.index == usb_irq_pkg::events_mask_index |=> ev_mask == $past(req.data[1:0]))
      else $error("event mask write lost");

   // ------------------------------------------------------------
   // Event status checks
   // ------------------------------------------------------------
   // Sticky bits: set by their event, kept until software writes a one
   status_set_a: assert property (@(posedge clock_in) disable iff (rst_in)
      in_event_in != 4'h0 |=> status[usb_irq_pkg::ev_in_flag_bit])
      else $error("flag event not recorded");
   status_frame_a: assert property (@(posedge clock_in) disable iff (rst_in)
      frame_valid_in |=> status[usb_irq_pkg::ev_frame_bit])
      else $error("frame event not recorded");
   status_sticky_a: assert property (@(posedge clock_in) disable iff (rst_in)
      status[usb_irq_pkg::ev_in_flag_bit] && !(wr && req.index == usb_irq_pkg::status_index)
      |=> status[usb_irq_pkg::ev_in_flag_bit])
      else $error("event status bit lost");
   // Write one clears, unless the same event arrives in that cycle
   status_clear_a: assert property (@(posedge clock_in) disable iff (rst_in)
      wr && req.sel[0] && req.index == usb_irq_pkg::status_index && in_event_in == 4'h0 && !frame_valid_in
      |=> (status & $past(req.data[1:0])) == 2'h0)
      else $error("event status not cleared");
   // The event line must follow the masked status both ways
   event_irq_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (status & ev_mask) != 2'h0 |-> irq_out)
      else $error("event interrupt missing");
   event_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (status & ev_mask) == 2'h0 |-> !irq_out)
      else $error("event interrupt without a cause");

   // ------------------------------------------------------------
   // Scenario covers
   // ------------------------------------------------------------

   flag_read_c: cover property (@(posedge clock_in) disable iff (rst_in)
      rd && req.index == usb_irq_pkg::in_flags_index && in_flags != 4'h0);
   set_clear_c: cover property (@(posedge clock_in) disable iff (rst_in)
      rd && req.index == usb_irq_pkg::in_flags_index && in_event_in != 4'h0);
   cpu_irq_c: cover property (@(posedge clock_in) disable iff (rst_in) cpu_irq_out);
   frame_capture_c: cover property (@(posedge clock_in) disable iff (rst_in)
      frame_valid_in && frame_number_in[10:8] != 3'h0);
   status_clear_c: cover property (@(posedge clock_in) disable iff (rst_in)
      wr && req.index == usb_irq_pkg::status_index && status != 2'h0);

endmodule

// File: verification/usb_function_irq_flags_frame_high_tb_top.sv
`timescale 1ns/1ns

module usb_function_irq_flags_frame_high_tb_top;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat = 32'h00000000;
   logic [31:0] rdata;
   logic ack;
   logic [3:0] in_event = 4'h0;
   logic frame_valid = 1'b0;
   logic [10:0] frame_number = 11'h000;
   logic req_irq;
   logic cpu_irq;
   logic ev_irq;
   int errors = 0;
   int checked = 0;
   // Bit positions of the three interrupt levels for lvl
   localparam int lv_req = 0;
   localparam int lv_cpu = 1;
   localparam int lv_ev = 2;

   always #20 clock_in = ~clock_in;

   usb_function_irq_flags_frame_high i_dut (
      .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_sel_in(sel), .wb_adr_in(adr), .wb_dat_in(dat), .wb_dat_out(rdata), .wb_ack_out(ack),
      .in_event_in(in_event), .frame_valid_in(frame_valid), .frame_number_in(frame_number),
      .usb_irq_request_out(req_irq), .cpu_irq_out(cpu_irq), .irq_out(ev_irq)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One classic cycle; request held until ack is sampled, then one idle cycle
   task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         report_and_stop();
      end
      q = rdata;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clock_in);
      // Ack is a single-cycle pulse
      check({31'h0, ack}, 32'h00000000);
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h00000000, q);
      check(q, e);
   endtask

   // Levels are sampled mid-cycle, then the bench re-aligns to a rising edge
   task automatic lvl(input int which, input logic exp);
      logic [2:0] levels;
      @(negedge clock_in);
      levels = {ev_irq, cpu_irq, req_irq};
      check({31'h0, levels[which]}, {31'h0, exp});
      @(posedge clock_in);
   endtask

   task automatic pulse(input logic [3:0] v);
      in_event <= v;
      @(posedge clock_in);
      in_event <= 4'h0;
      @(posedge clock_in);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      rd(10'h008, 32'h0);
      rd(10'h034, 32'h0);
      rd(10'h3fc, 32'h0);
      // Each source alone, so a swapped bit shows
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         rd(10'h008, 32'h1 << i);
      end
      wr(10'h008, 32'hff);
      rd(10'h008, 32'h0);
      pulse(4'hf);
      lvl(lv_req, 1'b0);
      wr(10'h080, 32'h0f);
      lvl(lv_req, 1'b1);
      lvl(lv_cpu, 1'b0);
      wr(10'h084, 32'h1);
      lvl(lv_cpu, 1'b1);
      rd(10'h008, 32'h0f);
      lvl(lv_req, 1'b0);
      rd(10'h008, 32'h0);
      // An event in the very cycle of the clearing read must survive it
      in_event <= 4'h2;
      rd(10'h008, 32'h0);
      in_event <= 4'h0;
      rd(10'h008, 32'h2);
      // Only the top three frame bits must be kept
      frame_number <= 11'h5a3;
      frame_valid <= 1'b1;
      @(posedge clock_in);
      frame_valid <= 1'b0;
      @(posedge clock_in);
      rd(10'h034, 32'h5);
      wr(10'h034, 32'hff);
      rd(10'h034, 32'h5);
      // Sticky event status, mask and write-one-to-clear
      lvl(lv_ev, 1'b0);
      wr(10'h08c, 32'h3);
      lvl(lv_ev, 1'b1);
      rd(10'h088, 32'h3);
      wr(10'h088, 32'h3);
      lvl(lv_ev, 1'b0);
      // A second reset mid-run must clear what the run has left behind
      pulse(4'h8);
      rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      rd(10'h034, 32'h0);
      rd(10'h008, 32'h0);
      lvl(lv_ev, 1'b0);
      report_and_stop();
   end

   // A hang anywhere ends the run as a failure
   initial begin
      repeat (20000) @(posedge clock_in);
      errors++;
      report_and_stop();
   end
endmodule
